// file: design/crcsn_engine.sv
`timescale 1ns/1ps
// two-cycle byte engine: four bits per clock, holds the data register
module crcsn_engine (
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic        load,
	input  wire logic [15:0] load_val,
	input  wire logic        start,
	input  wire logic [7:0]  din,
	input  wire logic        poly_sel,
	input  wire logic        msb_first,
	output logic             idle,
	output logic [15:0]      crc
);
	import crcsn_pkg::*;

	crcsn_eng_s st_r;
	crcsn_eng_s st_nxt;

	// software load overrides any byte in flight
	always_comb begin
		st_nxt = st_r;
		if (load) begin
			st_nxt.crc   = load_val;
			st_nxt.phase = CRCSN_IDLE;
		end else begin
			case (st_r.phase)
				CRCSN_IDLE: begin
					if (start) begin
						st_nxt.poly_sel  = poly_sel;
						st_nxt.msb_first = msb_first;
						st_nxt.crc  = crcsn_shift(st_r.crc, din, 4, poly_sel, msb_first);
						st_nxt.data = msb_first ? {din[3:0], 4'h0} : {4'h0, din[7:4]};
						st_nxt.phase = CRCSN_HALF1;
					end
				end
				CRCSN_HALF1: begin
					// second nibble finishes the byte on the second edge
					st_nxt.crc = crcsn_shift(st_r.crc, st_r.data, 4,
						st_r.poly_sel, st_r.msb_first);
					st_nxt.phase = CRCSN_IDLE;
				end
				default: st_nxt.phase = CRCSN_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			st_r <= '{phase: CRCSN_IDLE, crc: `CRCSN_DATA_RST, data: 8'h00,
				poly_sel: 1'b0, msb_first: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign idle = (st_r.phase == CRCSN_IDLE);
	assign crc  = st_r.crc;

	property p_two_cycle;
		@(posedge mclk) disable iff (!resetn)
		(start && idle && !load) |=> !idle ##1 idle;
	endproperty
	a_two_cycle: assert property (p_two_cycle) else $error("byte update not two cycles");

	property p_byte_result;
		@(posedge mclk) disable iff (!resetn)
		(start && idle && !load) ##1 !load |=>
			crc == $past(crcsn_shift(crc, din, 8, poly_sel, msb_first), 2);
	endproperty
	a_byte_result: assert property (p_byte_result) else $error("crc of byte wrong");
endmodule : crcsn_engine

// file: design/crcsn_params.svh
`ifndef CRCSN_PARAMS_SVH
`define CRCSN_PARAMS_SVH

// register indices on the local port
`define CRCSN_REG_DATA      3'h0
`define CRCSN_REG_INPUT     3'h1
`define CRCSN_REG_MODE      3'h2
`define CRCSN_REG_SNOOP     3'h3
`define CRCSN_REG_STATUS    3'h4

// reset values
`define CRCSN_DATA_RST      16'h0000
`define CRCSN_MODE_RST      8'h00
`define CRCSN_SNOOP_RST     16'h0000

// field positions
`define CRCSN_MODE_POLY     0
`define CRCSN_MODE_ORDER    5
`define CRCSN_SNP_WR_EN     15
`define CRCSN_SNP_RD_EN     14
`define CRCSN_SNP_MASK      16'hc3ff
`define CRCSN_ST_BUSY       0
`define CRCSN_ST_PEND       1
`define CRCSN_ST_OVERRUN    2

// polynomials, normal and reflected form
`define CRCSN_POLY_CCITT    16'h1021
`define CRCSN_POLY_CCITT_R  16'h8408
`define CRCSN_POLY_C16      16'h8005
`define CRCSN_POLY_C16_R    16'ha001

// peripheral register area: upper address bits must be zero
`define CRCSN_SFR_HI_ZERO   10'h000

// cycles taken per byte
`define CRCSN_UPDATE_CYCLES 2

`endif

// file: design/crcsn_pkg.sv
package crcsn_pkg;
	`include "crcsn_params.svh"

	// engine phases, gray along idle -> first half -> second half
	typedef enum logic [1:0] {
		CRCSN_IDLE  = 2'b00,
		CRCSN_HALF1 = 2'b01,
		CRCSN_HALF2 = 2'b11
	} crcsn_phase_e;

	typedef struct packed {
		crcsn_phase_e phase;
		logic [15:0]  crc;
		logic [7:0]   data;
		logic         poly_sel;
		logic         msb_first;
	} crcsn_eng_s;

	typedef struct packed {
		logic [15:0] rdata;
		logic [7:0]  in_byte;
		logic [7:0]  mode;
		logic [15:0] snp_cfg;
		logic        pend;
		logic [7:0]  pend_byte;
		logic        overrun;
	} crcsn_top_s;

	// shift nbits of data into crc, starting at bit 7 or bit 0
	function automatic logic [15:0] crcsn_shift(
		input logic [15:0] crc,
		input logic [7:0]  data,
		input int unsigned nbits,
		input logic        poly_sel,
		input logic        msb_first
	);
		logic [15:0] c;
		logic [7:0]  d;
		logic        fb;
		c = crc;
		d = data;
		fb = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (i < nbits) begin
				if (msb_first) begin
					fb = c[15] ^ d[7];
					c  = {c[14:0], 1'b0};
					if (fb) begin
						c = c ^ (poly_sel ? `CRCSN_POLY_C16 : `CRCSN_POLY_CCITT);
					end
					d = {d[6:0], 1'b0};
				end else begin
					fb = c[0] ^ d[0];
					c  = {1'b0, c[15:1]};
					if (fb) begin
						c = c ^ (poly_sel ? `CRCSN_POLY_C16_R : `CRCSN_POLY_CCITT_R);
					end
					d = {1'b0, d[7:1]};
				end
			end
		end
		return c;
	endfunction : crcsn_shift
endpackage : crcsn_pkg

// file: design/crcsn_top.sv
`timescale 1ns/1ps
// byte crc unit with local register port and bus snoop
module crcsn_top (
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic [2:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [15:0]      reg_rdata,
	input  wire logic        snp_valid,
	input  wire logic        snp_write,
	input  wire logic        snp_word,
	input  wire logic [19:0] snp_addr,
	input  wire logic [15:0] snp_data,
	output logic [15:0]      crc_value
);
	import crcsn_pkg::*;

	crcsn_top_s  st_r;
	crcsn_top_s  st_nxt;
	logic        eng_idle;
	logic [15:0] eng_crc;
	logic        eng_load;
	logic        eng_start;
	logic [7:0]  eng_din;
	logic [9:0]  mon_addr;
	logic        in_sfr;
	logic        lo_hit;
	logic        hi_hit;
	logic        snp_en;
	logic        snp_ev;
	logic [7:0]  snp_byte;
	logic        sw_ev;
	logic        ev;
	logic [7:0]  ev_byte;

	// snoop decode: only the register area, one byte from the right lane
	always_comb begin
		mon_addr = st_r.snp_cfg[9:0];
		in_sfr   = (snp_addr[19:10] == `CRCSN_SFR_HI_ZERO);
		lo_hit   = in_sfr && (snp_addr[9:0] == mon_addr);
		hi_hit   = in_sfr && snp_word && (10'(snp_addr[9:0] + 10'h001) == mon_addr);
		snp_en   = snp_write ? st_r.snp_cfg[`CRCSN_SNP_WR_EN]
		                     : st_r.snp_cfg[`CRCSN_SNP_RD_EN];
		snp_ev   = snp_valid && snp_en && (lo_hit || hi_hit);
		snp_byte = lo_hit ? snp_data[7:0] : snp_data[15:8];
	end

	// byte sources: a software write wins over a snoop in the same cycle
	assign sw_ev   = reg_wr && (reg_addr == `CRCSN_REG_INPUT);
	assign ev      = sw_ev || snp_ev;
	assign ev_byte = sw_ev ? reg_wdata[7:0] : snp_byte;

	// a waiting byte goes first so the stream keeps its order
	assign eng_load  = reg_wr && (reg_addr == `CRCSN_REG_DATA);
	assign eng_start = eng_idle && !eng_load && (st_r.pend || ev);
	assign eng_din   = st_r.pend ? st_r.pend_byte : ev_byte;

	// register file, pending byte and overrun flag
	always_comb begin
		st_nxt = st_r;
		st_nxt.rdata = 16'h0000;
		if (reg_rd) begin
			case (reg_addr)
				`CRCSN_REG_DATA:   st_nxt.rdata = eng_crc;
				`CRCSN_REG_INPUT:  st_nxt.rdata = {8'h00, st_r.in_byte};
				`CRCSN_REG_MODE:   st_nxt.rdata = {8'h00, st_r.mode};
				`CRCSN_REG_SNOOP:  st_nxt.rdata = st_r.snp_cfg;
				`CRCSN_REG_STATUS: st_nxt.rdata = {13'h0000, st_r.overrun, st_r.pend, !eng_idle};
				default:           st_nxt.rdata = 16'h0000;
			endcase
		end
		if (reg_wr) begin
			case (reg_addr)
				`CRCSN_REG_MODE:   st_nxt.mode = reg_wdata[7:0];
				`CRCSN_REG_SNOOP:  st_nxt.snp_cfg = reg_wdata & `CRCSN_SNP_MASK;
				`CRCSN_REG_STATUS: begin
					if (reg_wdata[`CRCSN_ST_OVERRUN]) begin
						st_nxt.overrun = 1'b0;
					end
				end
				default: st_nxt.in_byte = st_r.in_byte;
			endcase
		end
		if (ev) begin
			st_nxt.in_byte = ev_byte;
		end
		// pending slot: one byte deep, a third byte is dropped and flagged
		if (st_r.pend) begin
			if (eng_start) begin
				st_nxt.pend      = ev;
				st_nxt.pend_byte = ev ? ev_byte : st_r.pend_byte;
			end else if (ev) begin
				st_nxt.overrun = 1'b1;
			end
		end else if (ev && !eng_start) begin
			st_nxt.pend      = 1'b1;
			st_nxt.pend_byte = ev_byte;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			st_r <= '{rdata: 16'h0000, in_byte: 8'h00, mode: `CRCSN_MODE_RST,
				snp_cfg: `CRCSN_SNOOP_RST, pend: 1'b0, pend_byte: 8'h00, overrun: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	crcsn_engine u_engine (
		.mclk      (mclk),
		.resetn    (resetn),
		.load      (eng_load),
		.load_val  (reg_wdata),
		.start     (eng_start),
		.din       (eng_din),
		.poly_sel  (st_r.mode[`CRCSN_MODE_POLY]),
		.msb_first (st_r.mode[`CRCSN_MODE_ORDER]),
		.idle      (eng_idle),
		.crc       (eng_crc)
	);

	assign reg_rdata = st_r.rdata;
	assign crc_value = eng_crc;

	property p_load;
		@(posedge mclk) disable iff (!resetn)
		(reg_wr && reg_addr == `CRCSN_REG_DATA) |=> crc_value == $past(reg_wdata);
	endproperty
	a_load: assert property (p_load) else $error("data register load lost");

	property p_snoop_wr;
		@(posedge mclk) disable iff (!resetn)
		(snp_valid && snp_write && st_r.snp_cfg[15] && lo_hit && !sw_ev)
			|=> st_r.in_byte == $past(snp_data[7:0]);
	endproperty
	a_snoop_wr: assert property (p_snoop_wr) else $error("snooped write not captured");

	property p_snoop_rd;
		@(posedge mclk) disable iff (!resetn)
		(snp_valid && !snp_write && st_r.snp_cfg[14] && lo_hit && !sw_ev)
			|=> st_r.in_byte == $past(snp_data[7:0]);
	endproperty
	a_snoop_rd: assert property (p_snoop_rd) else $error("snooped read not captured");

	property p_high_lane;
		@(posedge mclk) disable iff (!resetn)
		(snp_ev && !lo_hit && !sw_ev) |=> st_r.in_byte == $past(snp_data[15:8]);
	endproperty
	a_high_lane: assert property (p_high_lane) else $error("word cycle took wrong lane");

	property p_outside_area;
		@(posedge mclk) disable iff (!resetn)
		(snp_valid && snp_addr[19:10] != 10'h000 && !reg_wr && eng_idle && !st_r.pend)
			|=> eng_idle && !st_r.pend;
	endproperty
	a_outside_area: assert property (p_outside_area) else $error("snoop outside area");

	property p_disabled;
		@(posedge mclk) disable iff (!resetn)
		(snp_valid && snp_write && !st_r.snp_cfg[15] && !reg_wr && eng_idle && !st_r.pend)
			|=> eng_idle && !st_r.pend;
	endproperty
	a_disabled: assert property (p_disabled) else $error("disabled snoop fired");

	property p_pend_served;
		@(posedge mclk) disable iff (!resetn)
		(st_r.pend && eng_idle && !eng_load) |-> eng_start ##1 !eng_idle;
	endproperty
	a_pend_served: assert property (p_pend_served) else $error("waiting byte not started");

	property p_snoop_cfg;
		@(posedge mclk) disable iff (!resetn)
		(reg_wr && reg_addr == `CRCSN_REG_SNOOP) ##1 (reg_rd && reg_addr == `CRCSN_REG_SNOOP
			&& !reg_wr) |=> reg_rdata == ($past(reg_wdata, 2) & 16'hc3ff);
	endproperty
	a_snoop_cfg: assert property (p_snoop_cfg) else $error("snoop control readback wrong");

	property p_single_byte;
		@(posedge mclk) disable iff (!resetn)
		(snp_ev && snp_word && !sw_ev && eng_idle && !st_r.pend && !eng_load)
			|=> !st_r.pend ##1 eng_idle;
	endproperty
	a_single_byte: assert property (p_single_byte) else $error("word cycle gave two bytes");
endmodule : crcsn_top

// file: verification/crcsn_bus_model.sv
`timescale 1ns/1ps
// cpu/dma side of the peripheral bus, one access per call
module crcsn_bus_model (
	input  wire logic        mclk,
	output logic             snp_valid,
	output logic             snp_write,
	output logic             snp_word,
	output logic [19:0]      snp_addr,
	output logic [15:0]      snp_data
);
	initial begin
		snp_valid = 1'b0;
		snp_write = 1'b0;
		snp_word  = 1'b0;
		snp_addr  = 20'h0_0000;
		snp_data  = 16'h0000;
	end

	// one-cycle access; released address and data lines show the inverse so no stale value looks valid
	task automatic xfer(input logic w, input logic wd, input logic [19:0] a,
			input logic [15:0] d);
		@(posedge mclk);
		snp_valid <= 1'b1;
		snp_write <= w;
		snp_word  <= wd;
		snp_addr  <= a;
		snp_data  <= d;
		@(posedge mclk);
		snp_valid <= 1'b0;
		snp_addr  <= ~a;
		snp_data  <= ~d;
	endtask : xfer
endmodule : crcsn_bus_model

// file: verification/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
	$display("[FAIL] %0t mismatch got %h exp %h", $time, g, e); end end
module tb_top;
	logic        mclk;
	logic        resetn;
	logic [2:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [15:0] reg_rdata;
	logic        snp_valid;
	logic        snp_write;
	logic        snp_word;
	logic [19:0] snp_addr;
	logic [15:0] snp_data;
	logic [15:0] crc_value;
	logic [15:0] exp_crc;
	int          err_count;
	int          checks;
	int          cyc;

	crcsn_top i_crcsn_top (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.snp_valid(snp_valid), .snp_write(snp_write), .snp_word(snp_word),
		.snp_addr(snp_addr), .snp_data(snp_data), .crc_value(crc_value));
	crcsn_bus_model i_crcsn_bus_model (.mclk(mclk), .snp_valid(snp_valid),
		.snp_write(snp_write), .snp_word(snp_word), .snp_addr(snp_addr),
		.snp_data(snp_data));

	// 50 ns clock
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// bitwise reference, independent of the design's own shifter
	function automatic logic [15:0] ref_crc(input logic [15:0] c, input logic [7:0] d,
			input logic p, input logic m);
		for (int i = 0; i < 8; i++) begin
			if (m) begin
				c = (c[15] ^ d[7 - i]) ? ({c[14:0], 1'b0} ^ (p ? 16'h8005 : 16'h1021))
					: {c[14:0], 1'b0};
			end else begin
				c = (c[0] ^ d[i]) ? ((c >> 1) ^ (p ? 16'ha001 : 16'h8408)) : (c >> 1);
			end
		end
		return c;
	endfunction : ref_crc

	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr    <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, input logic [15:0] e);
		@(posedge mclk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd   <= 1'b0;
		#1;
		`CHK(reg_rdata, e)
	endtask : rd

	// write then read of one register on adjacent edges, strobes back to back
	task automatic wr_rd(input logic [2:0] a, input logic [15:0] d, input logic [15:0] e);
		@(posedge mclk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr    <= 1'b0;
		reg_rd    <= 1'b1;
		@(posedge mclk);
		reg_rd    <= 1'b0;
		#1;
		`CHK(reg_rdata, e)
	endtask : wr_rd

	// four writes on consecutive edges, lowest byte first; the gap-free burst
	// is the only way to fill the waiting slot and hit the overrun drop
	task automatic wr4(input logic [2:0] a, input logic [31:0] ds);
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk);
			reg_wr    <= 1'b1;
			reg_addr  <= a;
			reg_wdata <= {8'h00, ds[8 * i +: 8]};
		end
		@(posedge mclk);
		reg_wr    <= 1'b0;
	endtask : wr4

	// byte taken at the last edge of wr: result due one edge later
	task automatic chk_crc();
		@(posedge mclk);
		#1;
		`CHK(crc_value, exp_crc)
	endtask : chk_crc

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : wrap_up

	// hang guard, far above the roughly 125 cycles the tests need
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			wrap_up();
		end
	end

	initial begin
		logic [7:0] b;
		{reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
		{err_count, checks, cyc} = '0;
		resetn = 1'b0;
		repeat (5) @(posedge mclk);
		resetn <= 1'b1;
		rd(3'h0, 16'h0000);
		rd(3'h2, 16'h0000);
		rd(3'h3, 16'h0000);
		rd(3'h1, 16'h0000);
		rd(3'h4, 16'h0000);
		rd(3'h5, 16'h0000);
		$display("test reset done");
		// every polynomial and bit order over a three-byte stream
		for (int m = 0; m < 4; m++) begin
			wr(3'h2, 16'(m[0]) | (16'(m[1]) << 5));
			wr(3'h0, 16'hffff);
			exp_crc = 16'hffff;
			for (int k = 0; k < 3; k++) begin
				b = 8'h31 + 8'(k);
				exp_crc = ref_crc(exp_crc, b, m[0], m[1]);
				wr(3'h1, {8'h00, b});
				chk_crc();
			end
			rd(3'h0, exp_crc);
		end
		$display("test modes done");
		wr(3'h2, 16'h0000);
		wr_rd(3'h3, 16'hffff, 16'hc3ff);
		wr(3'h3, 16'h8101);
		wr(3'h0, 16'h0000);
		exp_crc = ref_crc(16'h0000, 8'hbb, 1'b0, 1'b0);
		i_crcsn_bus_model.xfer(1'b1, 1'b1, 20'h0_0100, 16'hbbaa);
		repeat (3) @(posedge mclk);
		#1;
		`CHK(crc_value, exp_crc)
		i_crcsn_bus_model.xfer(1'b0, 1'b0, 20'h0_0101, 16'h0077);
		i_crcsn_bus_model.xfer(1'b1, 1'b0, 20'h0_0501, 16'h0044);
		repeat (3) @(posedge mclk);
		#1;
		`CHK(crc_value, exp_crc)
		wr(3'h3, 16'h4101);
		i_crcsn_bus_model.xfer(1'b1, 1'b0, 20'h0_0101, 16'h0011);
		i_crcsn_bus_model.xfer(1'b0, 1'b0, 20'h0_0101, 16'h0066);
		exp_crc = ref_crc(exp_crc, 8'h66, 1'b0, 1'b0);
		repeat (3) @(posedge mclk);
		#1;
		`CHK(crc_value, exp_crc)
		rd(3'h1, 16'h0066);
		$display("test snoop done");
		// burst of four: third byte waits, fourth is dropped and flagged
		wr(3'h0, 16'h1d0f);
		exp_crc = ref_crc(16'h1d0f, 8'ha1, 1'b0, 1'b0);
		exp_crc = ref_crc(exp_crc, 8'hb2, 1'b0, 1'b0);
		exp_crc = ref_crc(exp_crc, 8'hc3, 1'b0, 1'b0);
		wr4(3'h1, 32'hd4c3_b2a1);
		repeat (2) @(posedge mclk);
		#1;
		`CHK(crc_value, exp_crc)
		rd(3'h4, 16'h0004);
		wr(3'h4, 16'h0004);
		rd(3'h4, 16'h0000);
		$display("test burst done");
		wrap_up();
	end
endmodule : tb_top
